/* File: rtl/dacctl_consts.svh */
`ifndef DACCTL_CONSTS_SVH
`define DACCTL_CONSTS_SVH

`define DC_CH          16
`define DC_DW          14
`define DC_FULL_SCALE  14'h3FFF
`define DC_CLK_NS      50
`define DC_RESET_NS    270000
`define DC_RESET_CYC   (`DC_RESET_NS / `DC_CLK_NS)
`define DC_CLEAR16_NS  20000
`define DC_CLEAR8_NS   15000
`define DC_CLEAR_CYC   13'((`DC_CLEAR16_NS / `DC_CLK_NS) - 1)
`define DC_WORD_BITS   24
`define DC_W_READ      23
`define DC_W_SEL       22:21
`define DC_W_CH        19:16
`define DC_SEL_CLR     2'h0
`define DC_SEL_GAIN    2'h1
`define DC_SEL_OFS     2'h2
`define DC_SEL_DATA    2'h3
`define DC_OFS_CTRL    4'h0
`define DC_OFS_STATUS  4'h4
`define DC_OFS_CLRCODE 4'h8
`define DC_CTRL_PD     0
`define DC_CTRL_PULL   1
`define DC_IN_RST      0
`define DC_IN_CLR      1
`define DC_IN_LD       2
`define DC_IN_FS       3
`define DC_IN_SCK      4
`define DC_IN_DIN      5

`endif

/* File: rtl/dacctl_pkg.sv */
`include "dacctl_consts.svh"
package dacctl_pkg;
    typedef logic [`DC_DW-1:0] dacctl_code_t;
    typedef logic [`DC_CH-1:0][`DC_DW-1:0] dacctl_bank_t;
    typedef enum logic [2:0] {DC_S_INIT, DC_S_RESET, DC_S_IDLE, DC_S_CALC,
                              DC_S_CLEAR} dacctl_state_e;
    typedef enum logic [1:0] {DC_C_IDLE, DC_C_ADD} dacctl_calc_e;
    typedef struct packed {
        dacctl_state_e state;
        logic [12:0]   cnt;
        logic [5:0]    sy1;
        logic [5:0]    sy2;
        logic [5:0]    sy3;
        logic          busy_n;
        logic          live;
        logic          hiz;
        logic          pull;
        logic [1:0]    ctrl;
        dacctl_code_t  clr_code;
        dacctl_bank_t  gain;
        dacctl_bank_t  offset;
        dacctl_bank_t  corrected_data_register;
        dacctl_bank_t  dac;
        logic [`DC_CH-1:0] dirty;
        logic          load_pend;
        logic          clr_pend;
        logic [`DC_WORD_BITS-1:0] sh_in;
        logic [4:0]    bits;
        logic [`DC_WORD_BITS-1:0] word;
        logic          word_vld;
        dacctl_code_t  rb;
        dacctl_code_t  sh_out;
        logic          dout;
        logic [3:0]    calc_ch;
        logic          av_wait;
        logic [31:0]   av_rdata;
    } dacctl_top_s;
    typedef struct packed {
        dacctl_calc_e  st;
        logic [28:0]   prod;
        dacctl_code_t  ofs;
        dacctl_code_t  res;
        logic          done;
    } dacctl_calc_s;
endpackage : dacctl_pkg

/* File: rtl/dacctl_calc.sv */
`timescale 1ns/1ps
`include "dacctl_consts.svh"
module dacctl_calc (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic                 start_i,
    input  wire dacctl_pkg::dacctl_code_t x1_i,
    input  wire dacctl_pkg::dacctl_code_t gain_i,
    input  wire dacctl_pkg::dacctl_code_t offset_i,
    output logic                      done_o,
    output dacctl_pkg::dacctl_code_t  result_o
);
    import dacctl_pkg::*;

    dacctl_calc_s c_q;
    dacctl_calc_s c_d;
    logic [15:0]  sum;

    // ----------------------------------------------
    // Corrected data: x1 * (gain + 1) / 2^14 + offset
    // ----------------------------------------------
    always_comb
    begin
        c_d = c_q;
        c_d.done = 1'b0;
        sum = 16'({1'b0, c_q.prod[28:14]}) + 16'(c_q.ofs);
        case (c_q.st)
            DC_C_IDLE:
            begin
                if (start_i)
                begin
                    c_d.prod = 29'(x1_i) * 29'({1'b0, gain_i} + 15'h0001);
                    c_d.ofs = offset_i;
                    c_d.st = DC_C_ADD;
                end
            end
            DC_C_ADD:
            begin
                // Saturate rather than wrap at full scale
                c_d.res = (sum > 16'(`DC_FULL_SCALE)) ? `DC_FULL_SCALE : sum[13:0];
                c_d.done = 1'b1;
                c_d.st = DC_C_IDLE;
            end
            default: c_d.st = DC_C_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            c_q <= '0;
        else
            c_q <= c_d;
    end

    assign done_o = c_q.done;
    assign result_o = c_q.res;
endmodule : dacctl_calc

/* File: rtl/dacctl_top.sv */
`timescale 1ns/1ps
`include "dacctl_consts.svh"
module dacctl_top #(
    parameter int RESET_CYCLES = `DC_RESET_CYC
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       clear_code_strobe_n_i,
    input  wire logic                       output_load_strobe_n_i,
    input  wire logic                       frame_n_i,
    input  wire logic                       sclk_i,
    input  wire logic                       din_i,
    output logic                            dout_o,
    output logic                            busy_n_o,
    output logic                            out_hiz_o,
    output logic                            out_pull_o,
    output logic                            pwr_down_o,
    output logic [`DC_CH*`DC_DW-1:0]        dac_code_o,
    input  wire logic [3:0]                 avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [31:0]                avs_writedata_i,
    output logic [31:0]                     avs_readdata_o,
    output logic                            avs_waitrequest_o
);
    import dacctl_pkg::*;

    dacctl_top_s st_q;
    dacctl_top_s n;
    logic        resetting;
    logic        rst_fall;
    logic        clr_fall;
    logic        ld_fall;
    logic        frame;
    logic        sck_fall;
    logic        sck_rise;
    logic        fs_fall;
    logic        calc_start;
    logic        calc_done;
    dacctl_code_t calc_res;
    logic [3:0]  w_ch;

    function automatic logic fell(input logic prev, input logic now);
        return prev & ~now;
    endfunction : fell

    // ----------------------------------------------
    // Pin edges, seen only after the second sync stage
    // ----------------------------------------------
    assign resetting = (st_q.state == DC_S_INIT) || (st_q.state == DC_S_RESET);
    assign rst_fall  = fell(st_q.sy3[`DC_IN_RST], st_q.sy2[`DC_IN_RST]);
    assign clr_fall  = fell(st_q.sy3[`DC_IN_CLR], st_q.sy2[`DC_IN_CLR]);
    assign ld_fall   = fell(st_q.sy3[`DC_IN_LD], st_q.sy2[`DC_IN_LD]);
    assign fs_fall   = fell(st_q.sy3[`DC_IN_FS], st_q.sy2[`DC_IN_FS]);
    assign sck_fall  = fell(st_q.sy3[`DC_IN_SCK], st_q.sy2[`DC_IN_SCK]);
    assign sck_rise  = fell(st_q.sy2[`DC_IN_SCK], st_q.sy3[`DC_IN_SCK]);
    assign frame     = ~st_q.sy2[`DC_IN_FS];
    assign w_ch      = st_q.word[`DC_W_CH];

    dacctl_calc dacctl_calc_inst (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .start_i   (calc_start),
        .x1_i      (st_q.word[`DC_DW-1:0]),
        .gain_i    (st_q.gain[w_ch]),
        .offset_i  (st_q.offset[w_ch]),
        .done_o    (calc_done),
        .result_o  (calc_res)
    );

    always_comb
    begin
        n = st_q;
        calc_start = 1'b0;
        n.sy1 = {din_i, sclk_i, frame_n_i, output_load_strobe_n_i,
                 clear_code_strobe_n_i, reset_n_i};
        n.sy2 = st_q.sy1;
        n.sy3 = st_q.sy2;

        // ----------------------------------------------
        // Serial port, dead while resetting
        // ----------------------------------------------
        if (!resetting)
        begin
            // A frame may open on the same edge as the first clock rise
            if (fs_fall)
            begin
                n.bits = 5'h00;
                n.sh_out = st_q.rb;
            end
            if (frame && sck_rise)
            begin
                n.dout = n.sh_out[`DC_DW-1];
                n.sh_out = {n.sh_out[`DC_DW-2:0], 1'b0};
            end
            if (frame && sck_fall)
            begin
                n.sh_in = {st_q.sh_in[`DC_WORD_BITS-2:0], st_q.sy2[`DC_IN_DIN]};
                n.bits = st_q.bits + 5'h01;
            end
        end

        // ----------------------------------------------
        // Sequencer
        // ----------------------------------------------
        case (st_q.state)
            DC_S_INIT:
            begin
                n.gain = {`DC_CH{`DC_FULL_SCALE}};
                n.offset = '0;
                n.corrected_data_register = '0;
                n.dac = '0;
                n.dirty = '0;
                n.ctrl = 2'h0;
                n.clr_code = '0;
                n.load_pend = 1'b0;
                n.clr_pend = 1'b0;
                n.word_vld = 1'b0;
                n.bits = 5'h00;
                n.rb = '0;
                n.cnt = 13'(RESET_CYCLES - 2);
                n.state = DC_S_RESET;
            end
            DC_S_RESET:
            begin
                if (st_q.cnt == 13'h0000)
                    n.state = DC_S_IDLE;
                else
                    n.cnt = st_q.cnt - 13'h0001;
            end
            DC_S_IDLE:
            begin
                if (st_q.load_pend)
                begin
                    for (int i = 0; i < `DC_CH; i++)
                    begin
                        if (st_q.dirty[i])
                            n.dac[i] = st_q.corrected_data_register[i];
                    end
                    n.dirty = '0;
                    n.load_pend = 1'b0;
                    n.live = 1'b1;
                end
                else if (st_q.clr_pend)
                begin
                    n.dac = {`DC_CH{st_q.clr_code}};
                    n.live = 1'b1;
                    n.clr_pend = 1'b0;
                    n.cnt = `DC_CLEAR_CYC;
                    n.state = DC_S_CLEAR;
                end
                else if (st_q.word_vld)
                begin
                    n.word_vld = 1'b0;
                    if (st_q.word[`DC_W_READ])
                    begin
                        case (st_q.word[`DC_W_SEL])
                            `DC_SEL_CLR:  n.rb = st_q.clr_code;
                            `DC_SEL_GAIN: n.rb = st_q.gain[w_ch];
                            `DC_SEL_OFS:  n.rb = st_q.offset[w_ch];
                            default:      n.rb = st_q.corrected_data_register[w_ch];
                        endcase
                    end
                    else
                    begin
                        case (st_q.word[`DC_W_SEL])
                            `DC_SEL_CLR:  n.clr_code = st_q.word[`DC_DW-1:0];
                            `DC_SEL_GAIN: n.gain[w_ch] = st_q.word[`DC_DW-1:0];
                            `DC_SEL_OFS:  n.offset[w_ch] = st_q.word[`DC_DW-1:0];
                            default:
                            begin
                                calc_start = 1'b1;
                                n.calc_ch = w_ch;
                                n.state = DC_S_CALC;
                            end
                        endcase
                    end
                end
            end
            DC_S_CALC:
            begin
                if (calc_done)
                begin
                    n.corrected_data_register[st_q.calc_ch] = calc_res;
                    n.dirty[st_q.calc_ch] = 1'b1;
                    // Strobe held low fires a load right after busy rises
                    if (!st_q.sy2[`DC_IN_LD])
                        n.load_pend = 1'b1;
                    n.state = DC_S_IDLE;
                end
            end
            DC_S_CLEAR:
            begin
                if (st_q.cnt == 13'h0000)
                    n.state = DC_S_IDLE;
                else
                    n.cnt = st_q.cnt - 13'h0001;
            end
            default: n.state = DC_S_INIT;
        endcase

        // Events set after the case so a set beats a same-cycle clear
        if (!resetting)
        begin
            if (ld_fall)
                n.load_pend = 1'b1;
            if (clr_fall)
                n.clr_pend = 1'b1;
            if (frame && sck_fall && st_q.bits == 5'(`DC_WORD_BITS - 1))
            begin
                n.word = {st_q.sh_in[`DC_WORD_BITS-2:0], st_q.sy2[`DC_IN_DIN]};
                n.word_vld = 1'b1;
                n.bits = 5'h00;
            end
            if (rst_fall)
                n.state = DC_S_INIT;
        end

        // ----------------------------------------------
        // Avalon slave: one wait cycle, then accept
        // ----------------------------------------------
        if ((avs_read_i || avs_write_i) && st_q.av_wait)
        begin
            n.av_wait = 1'b0;
            case (avs_address_i)
                `DC_OFS_CTRL:    n.av_rdata = {30'h0, st_q.ctrl};
                `DC_OFS_STATUS:  n.av_rdata = {27'h0, st_q.live, st_q.load_pend,
                                               st_q.state == DC_S_CLEAR, resetting,
                                               st_q.busy_n};
                `DC_OFS_CLRCODE: n.av_rdata = {18'h0, st_q.clr_code};
                default:         n.av_rdata = 32'h0;
            endcase
        end
        else if (!st_q.av_wait)
        begin
            n.av_wait = 1'b1;
            // Writes during reset are dropped, the bus still completes
            if (avs_write_i && !resetting)
            begin
                if (avs_address_i == `DC_OFS_CTRL)
                    n.ctrl = avs_writedata_i[1:0];
                else if (avs_address_i == `DC_OFS_CLRCODE)
                    n.clr_code = avs_writedata_i[`DC_DW-1:0];
            end
        end

        n.busy_n = (n.state == DC_S_IDLE);
        n.hiz = !n.live || (n.ctrl[`DC_CTRL_PD] && !n.ctrl[`DC_CTRL_PULL]);
        n.pull = n.ctrl[`DC_CTRL_PD] && n.ctrl[`DC_CTRL_PULL];
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
            st_q.av_wait <= 1'b1;
            st_q.hiz <= 1'b1;
        end
        else
        begin
            st_q <= n;
        end
    end

    assign busy_n_o = st_q.busy_n;
    assign dout_o = st_q.dout;
    assign out_hiz_o = st_q.hiz;
    assign out_pull_o = st_q.pull;
    assign pwr_down_o = st_q.ctrl[`DC_CTRL_PD];
    assign dac_code_o = st_q.dac;
    assign avs_readdata_o = st_q.av_rdata;
    assign avs_waitrequest_o = st_q.av_wait;

    // ----------------------------------------------
    // Checks
    // ----------------------------------------------
    logic [12:0] rst_age;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            rst_age <= 13'h0000;
        else if (resetting)
            rst_age <= rst_age + 13'h0001;
        else
            rst_age <= 13'h0000;
    end

    a_reset_defaults: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (st_q.state == DC_S_INIT) |=>
            (st_q.dac == '0) && (st_q.offset == '0) && (&st_q.gain) && (st_q.dirty == '0))
        else $error("reset did not restore defaults");

    a_reset_bound: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        resetting |-> (rst_age < 13'(RESET_CYCLES)) && !busy_n_o)
        else $error("reset sequence too long or busy high");

    a_reset_level: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (st_q.state == DC_S_IDLE) && !st_q.sy2[`DC_IN_RST] && !st_q.sy3[`DC_IN_RST]
            |=> st_q.state != DC_S_INIT)
        else $error("reset level restarted the sequence");

    a_strobe_dropped: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (st_q.state == DC_S_RESET) |-> !st_q.load_pend && !st_q.word_vld)
        else $error("strobe or word kept during reset");

    a_clear_fill: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        $rose(st_q.state == DC_S_CLEAR) |->
            (st_q.dac == {`DC_CH{$past(st_q.clr_code)}}) && !busy_n_o)
        else $error("clear code not loaded");

    a_clear_span: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        $rose(st_q.state == DC_S_CLEAR) |-> ##[1:400] (st_q.state != DC_S_CLEAR))
        else $error("clear took too long");

    a_calc_busy: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (st_q.state == DC_S_CALC) |-> !busy_n_o ##1 (busy_n_o || st_q.state != DC_S_IDLE))
        else $error("busy high during calculation");

    a_strobe_kept: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (st_q.state == DC_S_CALC) && ld_fall && !rst_fall |=> st_q.load_pend)
        else $error("strobe during calculation lost");

    a_strobe_level: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (st_q.state == DC_S_CALC) && calc_done && !st_q.sy2[`DC_IN_LD] && !rst_fall
            |=> st_q.load_pend ##1 (st_q.dirty == '0))
        else $error("held strobe did not update");

    a_load_dirty: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (st_q.state == DC_S_IDLE) && st_q.load_pend |=>
            (st_q.dac[0] == $past(st_q.dirty[0] ? st_q.corrected_data_register[0]
                                                : st_q.dac[0])))
        else $error("load touched an unwritten channel");

    a_poweron_hiz: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !st_q.live |-> out_hiz_o && !st_q.dac[0][0])
        else $error("outputs driven before first update");

    a_pd_pull: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        pwr_down_o |-> (out_pull_o == st_q.ctrl[`DC_CTRL_PULL]) && (out_hiz_o != out_pull_o))
        else $error("power-down output mode wrong");

    a_shift_in: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        frame && sck_fall && !resetting |=> st_q.sh_in[0] == $past(st_q.sy2[`DC_IN_DIN]))
        else $error("serial bit not captured on falling clock");
endmodule : dacctl_top

/* File: test/dacctl_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Serial host model
// ----------------------------------------
module dacctl_host (
    input  wire logic clk_sys_i,
    output logic      frame_n_o,
    output logic      sclk_o,
    output logic      din_o
);
    initial
    begin
        frame_n_o = 1'b1;
        sclk_o    = 1'b0;
        din_o     = 1'b0;
    end

    // Bit-serial port: three 8-bit bursts, clock parked low between them
    task automatic send(input logic [23:0] w);
        @(posedge clk_sys_i);
        frame_n_o <= 1'b0;
        for (int b = 0; b < 3; b++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                din_o  <= w[23-8*b-k];
                sclk_o <= 1'b1;
                repeat (4) @(posedge clk_sys_i);
                sclk_o <= 1'b0;
                repeat (4) @(posedge clk_sys_i);
            end
            repeat (4) @(posedge clk_sys_i);
        end
        frame_n_o <= 1'b1;
        din_o     <= ~w[0];
    endtask : send
endmodule : dacctl_host

/* File: test/dacctl_top_tb.sv */
`timescale 1ns/1ps
`include "dacctl_consts.svh"
module dacctl_top_tb;
    import dacctl_pkg::*;
    logic                    clk, rst_i, reset_n, clr_n, ld_n, fs_n, sck, din;
    logic                    dout, busy_n, hiz, pull, pd, wrq;
    logic [`DC_CH*`DC_DW-1:0] dac;
    logic [3:0]              adr;
    logic                    rd_s, wr_s;
    logic [31:0]             wd, rdd, rd;
    logic [13:0]             rbk;
    int                      n_fail, cmp_count, n;

    dacctl_host dacctl_host_inst (.clk_sys_i(clk), .frame_n_o(fs_n), .sclk_o(sck), .din_o(din));
    dacctl_top #(.RESET_CYCLES(20)) dacctl_top_inst (
        .clk_sys_i(clk), .rst_i(rst_i), .reset_n_i(reset_n), .clear_code_strobe_n_i(clr_n),
        .output_load_strobe_n_i(ld_n), .frame_n_i(fs_n), .sclk_i(sck), .din_i(din),
        .dout_o(dout), .busy_n_o(busy_n), .out_hiz_o(hiz), .out_pull_o(pull),
        .pwr_down_o(pd), .dac_code_o(dac), .avs_address_i(adr), .avs_read_i(rd_s),
        .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_readdata_o(rdd),
        .avs_waitrequest_o(wrq));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] chan(input int i);
        return {18'h0, dac[i*`DC_DW +: `DC_DW]};
    endfunction : chan

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr  <= a;
        rd_s <= !w;
        wr_s <= w;
        wd   <= d;
        // Only the watchdog ends a stalled request
        do
            @(posedge clk);
        while (wrq !== 1'b0);
        rd   = rdd;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        // Registered outputs show the write one edge later
        @(posedge clk);
    endtask : av

    task automatic wait_busy(input logic v, input int lim);
        n = 0;
        while (busy_n !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(busy_n, v);
    endtask : wait_busy

    task automatic pulse_ld();
        @(posedge clk);
        ld_n <= 1'b0;
        repeat (3) @(posedge clk);
        ld_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : pulse_ld

    task automatic data_word(input logic [3:0] c, input logic [13:0] x);
        // Busy falls before the host has closed its frame
        fork
            dacctl_host_inst.send({1'b0, `DC_SEL_DATA, 1'b0, c, 2'b00, x});
            wait_busy(1'b0, 400);
        join
        wait_busy(1'b1, 40);
    endtask : data_word

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        #(50 * 30000);
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        rst_i = 1'b1; reset_n = 1'b1; clr_n = 1'b1; ld_n = 1'b1;
        adr = 4'h0; rd_s = 1'b0; wr_s = 1'b0; wd = 32'h0;
        n_fail = 0; cmp_count = 0;
        repeat (10) @(posedge clk);
        rst_i <= 1'b0;
        @(posedge clk);
        chk({busy_n, hiz, chan(0)}, {2'b01, 32'h0});
        wait_busy(1'b1, 40);
        data_word(4'h3, 14'h1000);
        pulse_ld();
        chk({chan(3), chan(4)}, {32'h1000, 32'h0});
        chk(hiz, 1'b0);
        // Strobe held low: update must follow the busy rise
        @(posedge clk);
        ld_n <= 1'b0;
        data_word(4'h7, 14'h0155);
        repeat (4) @(posedge clk);
        chk(chan(7), 32'h0155);
        ld_n <= 1'b1;
        av(1'b1, `DC_OFS_CLRCODE, 32'h0ABC);
        @(posedge clk);
        clr_n <= 1'b0;
        wait_busy(1'b0, 10);
        wait_busy(1'b1, 410);
        chk(n <= 400, 1'b1);
        clr_n <= 1'b1;
        for (int i = 0; i < `DC_CH; i++)
            chk(chan(i), 32'h0ABC);
        // No channel written since the last load
        pulse_ld();
        chk({chan(3), chan(7)}, {32'h0ABC, 32'h0ABC});
        av(1'b1, `DC_OFS_CTRL, 32'h1);
        chk({pd, pull}, 2'b10);
        av(1'b1, `DC_OFS_CTRL, 32'h3);
        chk({pd, pull, chan(5)}, {2'b11, 32'h0ABC});
        av(1'b1, `DC_OFS_CTRL, 32'h0);
        chk({pd, chan(5)}, {1'b0, 32'h0ABC});
        av(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
        // Channel 2 gain and offset changed, gain read back over the link
        dacctl_host_inst.send({1'b0, `DC_SEL_GAIN, 1'b0, 4'h2, 2'b00, 14'h1FFF});
        dacctl_host_inst.send({1'b0, `DC_SEL_OFS, 1'b0, 4'h2, 2'b00, 14'h0010});
        dacctl_host_inst.send({1'b1, `DC_SEL_GAIN, 1'b0, 4'h2, 2'b00, 14'h0000});
        fork
            dacctl_host_inst.send({1'b1, `DC_SEL_GAIN, 1'b0, 4'h2, 2'b00, 14'h0000});
            for (int k = 0; k < 14; k++)
            begin
                @(negedge sck);
                rbk = {rbk[12:0], dout};
            end
        join
        chk(rbk, 32'h1FFF);
        // Reset pin: strobe and host write during it are dropped
        @(posedge clk);
        reset_n <= 1'b0;
        wait_busy(1'b0, 10);
        pulse_ld();
        av(1'b1, `DC_OFS_CTRL, 32'h1);
        wait_busy(1'b1, 40);
        chk({chan(3), chan(7)}, 64'h0);
        chk({pd, hiz}, 2'b00);
        av(1'b0, `DC_OFS_STATUS, 32'h0);
        chk(rd[3], 1'b0);
        repeat (30) @(posedge clk);
        chk(busy_n, 1'b1);
        reset_n <= 1'b1;
        // Default gain full scale, offset zero: code passes through
        data_word(4'h2, 14'h2000);
        pulse_ld();
        chk(chan(2), 32'h2000);
        // One-cycle strobe pulse that lands inside the calculation
        fork
            data_word(4'h9, 14'h0077);
            begin
                repeat (24) @(negedge sck);
                repeat (2) @(posedge clk);
                ld_n <= 1'b0;
                @(posedge clk);
                ld_n <= 1'b1;
            end
        join
        repeat (4) @(posedge clk);
        chk(chan(9), 32'h0077);
        give_verdict();
    end
endmodule : dacctl_top_tb
